/* File: shared/iot_pkg.sv */
// What this block does
// - output toggling runs only while config bits 7/6 select ordinary output
// - first delay is 32 bits; zero starts nothing, X toggles after X ms
// - first delay set, second zero: exactly one toggle, then stop
// - writing the second delay never starts toggling; remote writes it first
// - non-zero first-delay write starts the sequence, timed from the write
// - zero first-delay write stops toggling and clears the second delay
// - a stopped pin keeps its present level
// - both delays are full unsigned 32-bit millisecond counts
// - both delays non-zero: endless square wave, period is their sum
// - while toggling, level writes and indicator reconfiguration are ignored
// - second output pin has its own identical delay pair
// - duration measurement runs only while config bits 5/4 are zero
// - each input level change reports the previous level's hold time in ms
// - durations are unsigned 32-bit ms counts, saturating at all-ones
// - second input pin has its own identical duration report
// - notify only when enabled, within one connection interval
// - indicator mode: pin b shows sleep (1 asleep), pin a link (0 connected)
// - output-level writes drive only pins set to output
package iot_pkg;
  // time base
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
  // attribute handles
  localparam logic [15:0] H_CFG = 16'h0017;
  localparam logic [15:0] H_OUT = 16'h001a;
  localparam logic [15:0] H_IN = 16'h001d;
  localparam logic [15:0] H_A1 = 16'h0021;
  localparam logic [15:0] H_A2 = 16'h0024;
  localparam logic [15:0] H_B1 = 16'h0027;
  localparam logic [15:0] H_B2 = 16'h002a;
  localparam logic [15:0] H_DA = 16'h002d;
  localparam logic [15:0] H_DB = 16'h0031;
  localparam logic [15:0] H_CCA = H_DA + 16'h0001;
  localparam logic [15:0] H_CCB = H_DB + 16'h0001;
  // config bit positions and reset values
  localparam int unsigned B_OUT_A = 6;
  localparam int unsigned B_OUT_B = 7;
  localparam int unsigned B_IN_A = 4;
  localparam int unsigned B_IN_B = 5;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [3:0] IN_IDLE = 4'hf;
  localparam logic [31:0] DLY_RST = 32'h0;
  localparam logic [31:0] MS_MAX = 32'hffffffff;
  typedef struct packed {
    logic write;
    logic [15:0] handle;
    logic [31:0] wdata;
  } att_req_s;
  typedef struct packed {
    logic err;
    logic [31:0] rdata;
  } att_rsp_s;
  typedef struct packed {
    logic [15:0] handle;
    logic [31:0] data;
  } ntf_s;
endpackage

/* File: core/toggle_channel.sv */
`timescale 1ns/100ps
`default_nettype none
module toggle_channel #(
  parameter int unsigned MS_CYCLES = iot_pkg::MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic first_wr,
  input wire logic second_wr,
  input wire logic level_wr,
  input wire logic level_bit,
  input wire logic [31:0] wdata,
  output logic [31:0] first_q,
  output logic [31:0] second_q,
  output logic level_q,
  output logic active_q
);
  logic [31:0] pre_q;
  logic [31:0] cnt_q;
  logic phase_q;
  // prescaler restarts at each start, so the first delay is timed from the write
  wire logic tick = active_q && (pre_q == 32'(MS_CYCLES - 1));
  wire logic expire = tick && (cnt_q == 32'h1);
  wire logic zero_wr = first_wr && (wdata == iot_pkg::DLY_RST);
  wire logic start = first_wr && !zero_wr && enable;
  wire logic stop = zero_wr || !enable;

  // settings
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      first_q <= iot_pkg::DLY_RST;
      second_q <= iot_pkg::DLY_RST;
    end else begin
      if (first_wr) first_q <= wdata;
      if (zero_wr) second_q <= iot_pkg::DLY_RST;
      else if (second_wr) second_q <= wdata;
    end
  end

  // delay sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_q <= 32'h0;
      cnt_q <= 32'h0;
      phase_q <= 1'b0;
      active_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      pre_q <= (start || tick || !active_q) ? 32'h0 : pre_q + 32'h1;
      if (start) begin
        active_q <= 1'b1;
        cnt_q <= wdata;
        phase_q <= 1'b0;
      end else if (stop) begin
        active_q <= 1'b0;
      end else if (expire) begin
        if (!phase_q && second_q == iot_pkg::DLY_RST) active_q <= 1'b0;
        cnt_q <= phase_q ? first_q : second_q;
        phase_q <= !phase_q;
      end else if (tick) begin
        cnt_q <= cnt_q - 32'h1;
      end
      // a running sequence owns the level; direct writes only land when idle
      if (expire && !stop && !start) level_q <= !level_q;
      else if (level_wr && !active_q) level_q <= level_bit;
    end
  end

  AST_ZERO_STOPS: assert property (@(posedge ref_clk) disable iff (rst)
    zero_wr |=> !active_q && second_q == 32'h0 && $stable(level_q))
    else $error("zero first delay did not stop and clear");
  AST_SECOND_NO_START: assert property (@(posedge ref_clk) disable iff (rst)
    second_wr && !first_wr && !active_q |=> !active_q)
    else $error("second delay write started toggling");
  AST_START_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
    start |=> active_q && cnt_q == $past(wdata) && pre_q == 32'h0)
    else $error("start did not load first delay");
  AST_HOLD_LEVEL: assert property (@(posedge ref_clk) disable iff (rst)
    active_q && !expire |=> $stable(level_q))
    else $error("level moved while toggling without expiry");
  AST_ONE_SHOT: assert property (@(posedge ref_clk) disable iff (rst)
    expire && !phase_q && second_q == 32'h0 && !first_wr && enable
    |=> !active_q && level_q != $past(level_q))
    else $error("single toggle did not end the sequence");
  AST_RELOAD: assert property (@(posedge ref_clk) disable iff (rst)
    expire && phase_q && !first_wr && enable |=> cnt_q == $past(first_q) && active_q)
    else $error("second phase did not reload first delay");
  COV_SQUARE: cover property (@(posedge ref_clk) disable iff (rst)
    expire && phase_q && enable);
  COV_ONE_SHOT: cover property (@(posedge ref_clk) disable iff (rst)
    expire && !phase_q && second_q == 32'h0);
endmodule
`default_nettype wire

/* File: core/level_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module level_timer #(
  parameter int unsigned MS_CYCLES = iot_pkg::MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic level,
  output logic [31:0] dur_q,
  output logic captured_q
);
  logic prev_q;
  logic primed_q;
  logic [31:0] pre_q;
  logic [31:0] cnt_q;
  // primed_q keeps the first sample after reset from looking like an edge
  wire logic edge_seen = enable && primed_q && (level != prev_q);
  wire logic tick = pre_q == 32'(MS_CYCLES - 1);

  // hold-time counter, restarted at every level change
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_q <= 1'b0;
      primed_q <= 1'b0;
      pre_q <= 32'h0;
      cnt_q <= 32'h0;
      dur_q <= iot_pkg::DLY_RST;
      captured_q <= 1'b0;
    end else begin
      prev_q <= level;
      primed_q <= 1'b1;
      captured_q <= edge_seen;
      if (edge_seen) dur_q <= cnt_q;
      if (!enable || edge_seen) begin
        pre_q <= 32'h0;
        cnt_q <= 32'h0;
      end else begin
        pre_q <= tick ? 32'h0 : pre_q + 32'h1;
        if (tick && cnt_q != iot_pkg::MS_MAX) cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  AST_CAPTURE: assert property (@(posedge ref_clk) disable iff (rst)
    edge_seen |=> captured_q && dur_q == $past(cnt_q) && cnt_q == 32'h0)
    else $error("level change not captured with old hold time");
  AST_SATURATE: assert property (@(posedge ref_clk) disable iff (rst)
    cnt_q == iot_pkg::MS_MAX && enable && !edge_seen |=> cnt_q == iot_pkg::MS_MAX)
    else $error("duration counter wrapped");
  AST_DISABLED: assert property (@(posedge ref_clk) disable iff (rst)
    !enable |=> !captured_q)
    else $error("capture while measurement disabled");
  COV_CAPTURE: cover property (@(posedge ref_clk) disable iff (rst)
    edge_seen && cnt_q != 32'h0);
endmodule
`default_nettype wire

/* File: core/timed_toggle_and_pulse_width.sv */
`timescale 1ns/100ps
`default_nettype none
module timed_toggle_and_pulse_width #(
  parameter int unsigned MS_CYCLES = iot_pkg::MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic att_valid,
  input wire iot_pkg::att_req_s att_req,
  output logic att_ack,
  output iot_pkg::att_rsp_s att_rsp,
  output logic ntf_valid,
  output iot_pkg::ntf_s ntf,
  input wire logic ntf_ready,
  input wire logic sleeping,
  input wire logic link_connected,
  input wire logic measured_in_a,
  input wire logic measured_in_b,
  output logic toggle_out_a,
  output logic toggle_out_b
);
  // pin synchroniser
  logic [1:0] meta_q;
  logic [1:0] sync_q;

  // settings held here, the rest live in the channels
  logic [7:0] cfg_q;
  logic cc_a_q;
  logic cc_b_q;

  // notify requests waiting for the link
  logic pend_a_q;
  logic pend_b_q;

  // channel settings and state
  logic [31:0] a1;
  logic [31:0] a2;
  logic [31:0] b1;
  logic [31:0] b2;
  logic lvl_a;
  logic lvl_b;
  logic act_a;
  logic act_b;
  logic [31:0] dur_a;
  logic [31:0] dur_b;
  logic cap_a;
  logic cap_b;

  function automatic logic hit(input logic [15:0] h, input logic [15:0] want);
    return h == want;
  endfunction

  // input pins come from outside, two flops before use; no reset, so the
  // chain holds real pin levels when reset lifts and no false edge follows
  always_ff @(posedge ref_clk) begin
    meta_q <= {measured_in_b, measured_in_a};
    sync_q <= meta_q;
  end

  // attribute decode
  wire logic [15:0] h = att_req.handle;
  wire logic [31:0] wd = att_req.wdata;
  wire logic wr = att_valid && att_req.write;
  wire logic wr_cfg = wr && hit(h, iot_pkg::H_CFG);
  wire logic wr_out = wr && hit(h, iot_pkg::H_OUT);
  wire logic wr_a1 = wr && hit(h, iot_pkg::H_A1);
  wire logic wr_a2 = wr && hit(h, iot_pkg::H_A2);
  wire logic wr_b1 = wr && hit(h, iot_pkg::H_B1);
  wire logic wr_b2 = wr && hit(h, iot_pkg::H_B2);
  wire logic wr_cca = wr && hit(h, iot_pkg::H_CCA);
  wire logic wr_ccb = wr && hit(h, iot_pkg::H_CCB);
  // result and input-level attributes refuse writes
  wire logic ro = hit(h, iot_pkg::H_IN) || hit(h, iot_pkg::H_DA)
    || hit(h, iot_pkg::H_DB);
  wire logic rw = hit(h, iot_pkg::H_CFG) || hit(h, iot_pkg::H_OUT)
    || hit(h, iot_pkg::H_A1) || hit(h, iot_pkg::H_A2)
    || hit(h, iot_pkg::H_B1) || hit(h, iot_pkg::H_B2)
    || hit(h, iot_pkg::H_CCA) || hit(h, iot_pkg::H_CCB);
  wire logic ok = rw || (ro && !att_req.write);

  // per-handle selects for the read-back checks
  wire logic rd_ok = att_valid && !att_req.write;
  wire logic sel_cfg = hit(h, iot_pkg::H_CFG);
  wire logic sel_out = hit(h, iot_pkg::H_OUT);
  wire logic sel_in = hit(h, iot_pkg::H_IN);
  wire logic sel_a1 = hit(h, iot_pkg::H_A1);
  wire logic sel_a2 = hit(h, iot_pkg::H_A2);
  wire logic sel_b1 = hit(h, iot_pkg::H_B1);
  wire logic sel_b2 = hit(h, iot_pkg::H_B2);
  wire logic sel_da = hit(h, iot_pkg::H_DA);
  wire logic sel_db = hit(h, iot_pkg::H_DB);
  wire logic sel_cca = hit(h, iot_pkg::H_CCA);
  wire logic sel_ccb = hit(h, iot_pkg::H_CCB);

  // mode bits
  wire logic en_a = cfg_q[iot_pkg::B_OUT_A];
  wire logic en_b = cfg_q[iot_pkg::B_OUT_B];
  wire logic meas_a = !cfg_q[iot_pkg::B_IN_A];
  wire logic meas_b = !cfg_q[iot_pkg::B_IN_B];
  // a running channel locks its own mode bit until stopped
  wire logic bit_a = act_a ? en_a : wd[iot_pkg::B_OUT_A];
  wire logic bit_b = act_b ? en_b : wd[iot_pkg::B_OUT_B];
  wire logic [7:0] cfg_d = {bit_b, bit_a, wd[5:0]};

  // read selection
  wire logic [31:0] rdata =
    hit(h, iot_pkg::H_CFG) ? {24'h0, cfg_q} :
    hit(h, iot_pkg::H_OUT) ? {24'h0, lvl_b, lvl_a, 6'h0} :
    hit(h, iot_pkg::H_IN) ? {24'h0, 2'h0, sync_q, iot_pkg::IN_IDLE} :
    hit(h, iot_pkg::H_A1) ? a1 :
    hit(h, iot_pkg::H_A2) ? a2 :
    hit(h, iot_pkg::H_B1) ? b1 :
    hit(h, iot_pkg::H_B2) ? b2 :
    hit(h, iot_pkg::H_DA) ? dur_a :
    hit(h, iot_pkg::H_DB) ? dur_b :
    hit(h, iot_pkg::H_CCA) ? {31'h0, cc_a_q} :
    hit(h, iot_pkg::H_CCB) ? {31'h0, cc_b_q} :
    32'h0;

  // settings and one-cycle answer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_q <= iot_pkg::CFG_RST;
      cc_a_q <= 1'b0;
      cc_b_q <= 1'b0;
      att_ack <= 1'b0;
      att_rsp <= '{err: 1'b0, rdata: 32'h0};
    end else begin
      if (wr_cfg) cfg_q <= cfg_d;
      if (wr_cca) cc_a_q <= wd[0];
      if (wr_ccb) cc_b_q <= wd[0];
      att_ack <= att_valid;
      att_rsp.err <= att_valid && !ok;
      att_rsp.rdata <= (att_valid && !att_req.write && ok) ? rdata : 32'h0;
    end
  end

  // output channels, one per pin
  toggle_channel #(.MS_CYCLES(MS_CYCLES)) u_tog_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(en_a),
    .first_wr(wr_a1),
    .second_wr(wr_a2),
    .level_wr(wr_out && en_a),
    .level_bit(wd[iot_pkg::B_OUT_A]),
    .wdata(wd),
    .first_q(a1),
    .second_q(a2),
    .level_q(lvl_a),
    .active_q(act_a)
  );

  // second pin, same behaviour with its own settings
  toggle_channel #(.MS_CYCLES(MS_CYCLES)) u_tog_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(en_b),
    .first_wr(wr_b1),
    .second_wr(wr_b2),
    .level_wr(wr_out && en_b),
    .level_bit(wd[iot_pkg::B_OUT_B]),
    .wdata(wd),
    .first_q(b1),
    .second_q(b2),
    .level_q(lvl_b),
    .active_q(act_b)
  );

  // input measurement, one per pin
  level_timer #(.MS_CYCLES(MS_CYCLES)) u_dur_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(meas_a),
    .level(sync_q[0]),
    .dur_q(dur_a),
    .captured_q(cap_a)
  );

  level_timer #(.MS_CYCLES(MS_CYCLES)) u_dur_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(meas_b),
    .level(sync_q[1]),
    .dur_q(dur_b),
    .captured_q(cap_b)
  );

  // notify arbiter: a wins ties; latest capture is what gets sent
  wire logic load = !ntf_valid || ntf_ready;
  wire logic take_a = load && pend_a_q;
  wire logic take_b = load && !pend_a_q && pend_b_q;
  // a disable written this cycle drops the pending request at once; an offer
  // already made, or taken in that same cycle, still goes out after the enable has gone
  wire logic keep_a = cc_a_q && !(wr_cca && !wd[0]);
  wire logic keep_b = cc_b_q && !(wr_ccb && !wd[0]);
  // a new capture beats the clear in the same cycle
  wire logic pend_a_d = ((pend_a_q && !take_a) || cap_a) && keep_a;
  wire logic pend_b_d = ((pend_b_q && !take_b) || cap_b) && keep_b;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_a_q <= 1'b0;
      pend_b_q <= 1'b0;
      ntf_valid <= 1'b0;
      ntf <= '{handle: 16'h0, data: 32'h0};
    end else begin
      pend_a_q <= pend_a_d;
      pend_b_q <= pend_b_d;
      if (take_a) begin
        ntf_valid <= 1'b1;
        ntf <= '{handle: iot_pkg::H_DA, data: dur_a};
      end else if (take_b) begin
        ntf_valid <= 1'b1;
        ntf <= '{handle: iot_pkg::H_DB, data: dur_b};
      end else if (ntf_ready) begin
        ntf_valid <= 1'b0;
      end
    end
  end

  // pins: toggled level in output mode, indicators otherwise
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      toggle_out_a <= 1'b1;
      toggle_out_b <= 1'b0;
    end else begin
      toggle_out_a <= en_a ? lvl_a : !link_connected;
      toggle_out_b <= en_b ? lvl_b : sleeping;
    end
  end

  AST_INDICATOR: assert property (@(posedge ref_clk) disable iff (rst)
    !en_a && !en_b |=> toggle_out_a == !$past(link_connected)
    && toggle_out_b == $past(sleeping))
    else $error("indicator pins do not follow status");
  AST_PIN_LEVEL: assert property (@(posedge ref_clk) disable iff (rst)
    en_a |=> toggle_out_a == $past(lvl_a))
    else $error("output pin does not follow channel level");
  AST_CFG_LOCK: assert property (@(posedge ref_clk) disable iff (rst)
    wr_cfg && act_a |=> en_a == $past(en_a))
    else $error("mode bit changed while toggling");
  AST_NTF_GATED: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(ntf_valid) && ntf.handle == iot_pkg::H_DA |-> $past(cc_a_q))
    else $error("notify sent without enable");
  AST_NTF_PROMPT: assert property (@(posedge ref_clk) disable iff (rst)
    cap_a && cc_a_q && !ntf_valid && !pend_b_q && !wr_cca
    ##1 !ntf_valid |=> ntf_valid && ntf.handle == iot_pkg::H_DA)
    else $error("capture not offered two cycles later");
  AST_NTF_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    ntf_valid && !ntf_ready |=> ntf_valid && $stable(ntf))
    else $error("notify dropped before accepted");
  AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (rst)
    att_valid && !ok |=> att_ack && att_rsp.err)
    else $error("bad handle not refused");
  COV_NTF_SENT: cover property (@(posedge ref_clk) disable iff (rst)
    ntf_valid && ntf_ready && ntf.handle == iot_pkg::H_DB);
  COV_LOCKED_WRITE: cover property (@(posedge ref_clk) disable iff (rst)
    wr_out && act_b);

  // reads return the addressed setting or result
  AST_RD_CFG: assert property (@(posedge ref_clk) disable iff (rst)
    rd_ok && sel_cfg |=> att_rsp.rdata == {24'h0, $past(cfg_q)})
    else $error("config read wrong");

  AST_RD_OUT: assert property (@(posedge ref_clk) disable iff (rst)
    rd_ok && sel_out |=> att_rsp.rdata == {24'h0, $past(lvl_b), $past(lvl_a), 6'h0})
    else $error("level read wrong");

  AST_RD_IN: assert property (@(posedge ref_clk) disable iff (rst)
    rd_ok && sel_in |=> att_rsp.rdata == {26'h0, $past(sync_q), iot_pkg::IN_IDLE})
    else $error("input read wrong");

  AST_RD_A1: assert property (@(posedge ref_clk) disable iff (rst)
    rd_ok && sel_a1 |=> att_rsp.rdata == $past(a1))
    else $error("a first read wrong");

  AST_RD_A2: assert property (@(posedge ref_clk) disable iff (rst)
    rd_ok && sel_a2 |=> att_rsp.rdata == $past(a2))
    else $error("a second read wrong");

  AST_RD_B1: assert property (@(posedge ref_clk) disable iff (rst)
    rd_ok && sel_b1 |=> att_rsp.rdata == $past(b1))
    else $error("b first read wrong");

  AST_RD_B2: assert property (@(posedge ref_clk) disable iff (rst)
    rd_ok && sel_b2 |=> att_rsp.rdata == $past(b2))
    else $error("b second read wrong");

  AST_RD_DA: assert property (@(posedge ref_clk) disable iff (rst)
    rd_ok && sel_da |=> att_rsp.rdata == $past(dur_a))
    else $error("a duration read wrong");

  AST_RD_DB: assert property (@(posedge ref_clk) disable iff (rst)
    rd_ok && sel_db |=> att_rsp.rdata == $past(dur_b))
    else $error("b duration read wrong");

  AST_RD_CCA: assert property (@(posedge ref_clk) disable iff (rst)
    rd_ok && sel_cca |=> att_rsp.rdata == {31'h0, $past(cc_a_q)})
    else $error("a enable read wrong");

  AST_RD_CCB: assert property (@(posedge ref_clk) disable iff (rst)
    rd_ok && sel_ccb |=> att_rsp.rdata == {31'h0, $past(cc_b_q)})
    else $error("b enable read wrong");

  // answer timing and refusals
  AST_ACK_NEXT: assert property (@(posedge ref_clk) disable iff (rst)
    att_valid |=> att_ack)
    else $error("request not answered");

  AST_ACK_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
    !att_valid |=> !att_ack && !att_rsp.err)
    else $error("answer without request");

  AST_WR_NO_DATA: assert property (@(posedge ref_clk) disable iff (rst)
    att_valid && att_req.write |=> att_rsp.rdata == 32'h0)
    else $error("write answered with data");

  AST_RO_REFUSED: assert property (@(posedge ref_clk) disable iff (rst)
    att_valid && att_req.write && ro |=> att_rsp.err)
    else $error("read-only write not refused");

  AST_CFG_LOCK_B: assert property (@(posedge ref_clk) disable iff (rst)
    wr_cfg && act_b |=> en_b == $past(en_b))
    else $error("b mode bit changed while toggling");

  AST_PIN_LEVEL_B: assert property (@(posedge ref_clk) disable iff (rst)
    en_b |=> toggle_out_b == $past(lvl_b))
    else $error("b pin does not follow level");

  AST_START_GATED: assert property (@(posedge ref_clk) disable iff (rst)
    wr_a1 && !en_a |=> !act_a)
    else $error("toggling outside output mode");

  AST_OUT_IGNORED: assert property (@(posedge ref_clk) disable iff (rst)
    wr_out && !en_a |=> lvl_a == $past(lvl_a))
    else $error("level write on non-output pin");

  AST_NTF_GATED_B: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(ntf_valid) && ntf.handle == iot_pkg::H_DB |-> $past(cc_b_q))
    else $error("b notify sent without enable");

  AST_NTF_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
    !cc_a_q && !cc_b_q && !ntf_valid |=> !ntf_valid)
    else $error("notify offered while disabled");

  AST_NTF_DATA_A: assert property (@(posedge ref_clk) disable iff (rst)
    take_a |=> ntf.handle == iot_pkg::H_DA && ntf.data == $past(dur_a))
    else $error("a notify carries wrong data");
endmodule
`default_nettype wire

/* File: test/remote_app_model.sv */
`timescale 1ns/100ps
`default_nettype none
// far-side application: issues attribute requests and takes notifications
module remote_app_model (
  input wire logic ref_clk,
  input wire logic slow,
  output logic att_valid,
  output iot_pkg::att_req_s att_req,
  input wire logic att_ack,
  input wire iot_pkg::att_rsp_s att_rsp,
  input wire logic ntf_valid,
  input wire iot_pkg::ntf_s ntf,
  output logic ntf_ready
);
  iot_pkg::ntf_s got_q[$];
  logic [1:0] cnt_q;

  initial begin
    att_valid = 1'b0;
    att_req = '0;
    ntf_ready = 1'b0;
    cnt_q = 2'h0;
  end

  // one request per call; the request fields are scrambled once taken so stale values never pass
  task automatic access(input logic wr, input logic [15:0] h, input logic [31:0] wd,
                        output iot_pkg::att_rsp_s rsp);
    int i;
    @(posedge ref_clk);
    att_valid <= 1'b1;
    att_req <= '{write: wr, handle: h, wdata: wd};
    @(posedge ref_clk);
    att_valid <= 1'b0;
    att_req <= iot_pkg::att_req_s'(~att_req);
    rsp = '1;
    for (i = 0; i < 4; i++) begin
      #1;
      if (att_ack) begin
        rsp = att_rsp;
        break;
      end
      @(posedge ref_clk);
    end
  endtask

  // slow mode accepts one offer in four, as a busy link would
  always @(posedge ref_clk) begin
    cnt_q <= cnt_q + 2'h1;
    ntf_ready <= slow ? (cnt_q == 2'h0) : 1'b1;
    if (ntf_valid && ntf_ready) got_q.push_back(ntf);
  end
endmodule
`default_nettype wire

/* File: test/timed_toggle_and_pulse_width_test.sv */
`timescale 1ns/100ps
`default_nettype none
module timed_toggle_and_pulse_width_test;
  localparam int M = 10;
  logic ref_clk, rst, slow, sleeping, link_connected, in_a, in_b, att_valid, att_ack;
  logic ntf_valid, ntf_ready, out_a, out_b, lvl, e;
  iot_pkg::att_req_s att_req;
  iot_pkg::att_rsp_s att_rsp;
  iot_pkg::ntf_s ntf, got;
  logic [31:0] seed, d;
  logic [15:0] hs[6];
  int bad_count, cmp_count, d1, d2, ms, k;

  timed_toggle_and_pulse_width #(.MS_CYCLES(M)) timed_toggle_and_pulse_width_i (
    .ref_clk(ref_clk), .rst(rst), .att_valid(att_valid), .att_req(att_req), .att_ack(att_ack),
    .att_rsp(att_rsp), .ntf_valid(ntf_valid), .ntf(ntf), .ntf_ready(ntf_ready), .sleeping(sleeping),
    .link_connected(link_connected), .measured_in_a(in_a), .measured_in_b(in_b),
    .toggle_out_a(out_a), .toggle_out_b(out_b));

  remote_app_model remote_app_model_i (
    .ref_clk(ref_clk), .slow(slow), .att_valid(att_valid), .att_req(att_req), .att_ack(att_ack),
    .att_rsp(att_rsp), .ntf_valid(ntf_valid), .ntf(ntf), .ntf_ready(ntf_ready));

  always #5 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] h, input logic [31:0] v);
    iot_pkg::att_rsp_s r;
    remote_app_model_i.access(1'b1, h, v, r);
  endtask

  task automatic rd(input logic [15:0] h, output logic [31:0] dv, output logic ev);
    iot_pkg::att_rsp_s r;
    remote_app_model_i.access(1'b0, h, 32'h0, r);
    dv = r.rdata;
    ev = r.err;
  endtask

  // cycles until the pin changes, capped at lim
  task automatic flip_time(input int which, input int lim, output int n);
    logic s;
    s = which ? out_b : out_a;
    n = 0;
    while (((which ? out_b : out_a) === s) && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask

  // the ms tick phase is free, so one ms of slack either side
  task automatic expect_flip(input int which, input int dms);
    int n;
    flip_time(which, dms * M + 3 * M, n);
    check(32'(n >= dms * M - M && n <= dms * M + M), 32'h1);
  endtask

  task automatic expect_hold(input int which, input int cyc);
    int n;
    flip_time(which, cyc, n);
    check(32'(n), 32'(cyc));
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the sequence needs a few hundred cycles at most
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    slow = 1'b0;
    sleeping = 1'b1;
    link_connected = 1'b0;
    in_a = 1'b1;
    in_b = 1'b1;
    seed = 32'h38b9f47c;
    bad_count = 0;
    cmp_count = 0;
    hs = '{iot_pkg::H_A1, iot_pkg::H_A2, iot_pkg::H_B1, iot_pkg::H_B2, iot_pkg::H_DA, iot_pkg::H_DB};
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    // indicator mode follows link and sleep status
    check(32'(out_a), 32'h1);
    check(32'(out_b), 32'h1);
    @(posedge ref_clk);
    link_connected <= 1'b1;
    sleeping <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    check(32'(out_a), 32'h0);
    check(32'(out_b), 32'h0);
    // power-on values, unknown handle, read-only result
    foreach (hs[i]) begin
      rd(hs[i], d, e);
      check(d, 32'h0);
    end
    rd(16'h0050, d, e);
    check(32'(e), 32'h1);
    wr(iot_pkg::H_DA, 32'h5);
    rd(iot_pkg::H_DA, d, e);
    check(d, 32'h0);
    // not in output mode: a first delay starts nothing
    wr(iot_pkg::H_A1, 32'h1);
    expect_hold(0, 3 * M);
    wr(iot_pkg::H_A1, 32'h0);
    wr(iot_pkg::H_CFG, 32'hc0);
    wr(iot_pkg::H_OUT, 32'h40);
    @(posedge ref_clk);
    #1;
    check(32'(out_a), 32'h1);
    check(32'(out_b), 32'h0);
    // square wave, second delay written first
    d1 = 2 + int'(xs() % 32'h3);
    d2 = 2 + int'(xs() % 32'h3);
    wr(iot_pkg::H_A2, 32'(d2));
    expect_hold(0, (d1 + d2) * M);
    wr(iot_pkg::H_A1, 32'(d1));
    expect_flip(0, d1);
    expect_flip(0, d2);
    wr(iot_pkg::H_OUT, 32'h00);
    wr(iot_pkg::H_CFG, 32'h80);
    expect_flip(0, d1);
    // stop keeps the present level and clears the second delay
    lvl = out_a;
    wr(iot_pkg::H_A1, 32'h0);
    check(32'(out_a), 32'(lvl));
    expect_hold(0, 4 * M);
    rd(iot_pkg::H_A2, d, e);
    check(d, 32'h0);
    wr(iot_pkg::H_OUT, {24'h0, 1'b0, ~lvl, 6'h0});
    @(posedge ref_clk);
    #1;
    check(32'(out_a), 32'(!lvl));
    // pin b single toggle
    d1 = 1 + int'(xs() % 32'h3);
    wr(iot_pkg::H_B2, 32'h0);
    wr(iot_pkg::H_B1, 32'(d1));
    expect_flip(1, d1);
    expect_hold(1, 6 * M);
    wr(iot_pkg::H_B1, 32'hffffffff);
    rd(iot_pkg::H_B1, d, e);
    check(d, 32'hffffffff);
    wr(iot_pkg::H_B1, 32'h0);
    // duration reports, the second with a stalling link
    wr(iot_pkg::H_CFG, 32'hc0);
    wr(iot_pkg::H_CCA, 32'h1);
    wr(iot_pkg::H_CCB, 32'h1);
    for (k = 0; k < 2; k++) begin
      ms = 2 + int'(xs() % 32'h3);
      @(posedge ref_clk);
      slow <= k[0];
      if (k == 0) in_a <= 1'b0;
      else in_b <= 1'b0;
      repeat (20) @(posedge ref_clk);
      remote_app_model_i.got_q.delete();
      repeat (ms * M - 20) @(posedge ref_clk);
      if (k == 0) in_a <= 1'b1;
      else in_b <= 1'b1;
      repeat (30) @(posedge ref_clk);
      #1;
      check(32'(remote_app_model_i.got_q.size()), 32'h1);
      got = remote_app_model_i.got_q.pop_front();
      check(32'(got.handle), 32'(k ? iot_pkg::H_DB : iot_pkg::H_DA));
      check(32'(got.data >= 32'(ms - 1) && got.data <= 32'(ms + 1)), 32'h1);
      rd(k ? iot_pkg::H_DB : iot_pkg::H_DA, d, e);
      check(d, got.data);
    end
    // no report with notify disabled, nor with measurement off
    wr(iot_pkg::H_CCB, 32'h0);
    wr(iot_pkg::H_CFG, 32'hd0);
    remote_app_model_i.got_q.delete();
    @(posedge ref_clk);
    in_b <= 1'b0;
    in_a <= 1'b0;
    repeat (40) @(posedge ref_clk);
    #1;
    check(32'(remote_app_model_i.got_q.size()), 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
